//--- hdl/wwc_pkg.sv
// constants, types and helpers shared by the watchdog and wake-up control block
// assumes a single 10 MHz system clock and an AHB-Lite register port
//
// What this block does
// RULE_01: sleep or idle wakes on enabled port A fall, interrupt or watchdog overflow
// RULE_02: deep sleep wakes only on enabled port A fall or time base zero interrupt
// RULE_03: halt sets power-down flag; power-up or clear-watchdog clears it
// RULE_04: overflow wake sets timeout flag, clears only program counter and stack pointer
// RULE_05: each port A pin has its own wake enable for falling edges
// RULE_06: pin wake resumes after halt from sleep or idle, restarts at zero from deep sleep
// RULE_07: disabled interrupt or full stack wake resumes after halt, request stays pending
// RULE_08: enabled interrupt with free stack level takes normal interrupt response
// RULE_09: time base zero wake from deep sleep restarts at address zero
// RULE_10: interrupt already requesting at low-power entry cannot wake from that mode
// RULE_11: watchdog counts only the low-speed 32kHz rc clock
// RULE_12: timeout select picks 2^8,10,12,14,15,16,17,18 low-speed clock periods
// RULE_13: always-enabled option runs watchdog for both valid key values
// RULE_14: register-controlled option stops on 10101 and runs on 01010
// RULE_15: any other key value resets device after delay and sets key reset flag
// RULE_16: power-on loads key 01010 and select 011, control reads 0x53
// RULE_17: key reset sets key reset flag bit 0; only software write of 0 clears
// RULE_18: overflow in normal running gives full device reset and sets timeout flag
// RULE_19: watchdog counter cleared by key reset, clear-watchdog or halt
// RULE_20: software must clear the watchdog before the selected period elapses
// RULE_21: on halt, deep sleep select and idle clock enables choose the mode
// RULE_22: entering low power clears watchdog, then it counts if enabled
// RULE_23: 18-bit up-counter overflows when the selected power-of-two bit sets

package wwc_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_WATCHDOG_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_RESET_CAUSE_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_PORT_A_WAKE       = 8'h08;
  localparam logic [7:0] ADDR_POWER_CONTROL     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS            = 8'h10;

  // ==========================================================
  // fields and reset values
  localparam int          KEY_LSB          = 3;
  localparam int          SEL_LSB          = 0;
  localparam logic [4:0]  KEY_RUN          = 5'h0a;
  localparam logic [4:0]  KEY_STOP         = 5'h15;
  localparam logic [7:0]  WDC_RESET        = 8'h53;
  localparam logic [3:0]  FLAGS_RESET      = 4'h0;
  localparam int          FLAG_WATCHDOG    = 0;
  localparam logic [7:0]  WAKE_EN_RESET    = 8'h00;
  localparam int          PWR_DEEP         = 0;
  localparam int          PWR_FAST_IDLE    = 1;
  localparam int          PWR_SLOW_IDLE    = 2;
  localparam logic [2:0]  PWR_RESET        = 3'h0;
  localparam int          STAT_PDF         = 0;
  localparam int          STAT_TO          = 1;
  localparam int          STAT_RUNNING     = 2;
  localparam int          STAT_MODE_LSB    = 4;
  localparam int          WDT_WIDTH        = 18;

  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_NS      = 100;
  localparam int          KEY_RESET_DELAY_NS = 20000;
  localparam int          KEY_RESET_CYCLES   =
    (KEY_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // gray order along run -> idle0 -> idle1 -> idle2 -> sleep -> deep sleep
  typedef enum logic [2:0] {
    MODE_RUN   = 3'h0,
    MODE_IDLE0 = 3'h1,
    MODE_IDLE1 = 3'h3,
    MODE_IDLE2 = 3'h2,
    MODE_SLEEP = 3'h6,
    MODE_DEEP  = 3'h7
  } wwc_mode_t;

  // counter bit whose setting marks the selected period
  function automatic logic [4:0] wwc_tap(input logic [2:0] sel);
    logic [4:0] tap;
    case (sel)
      3'h0:    tap = 5'h08;
      3'h1:    tap = 5'h0a;
      3'h2:    tap = 5'h0c;
      3'h3:    tap = 5'h0e;
      3'h4:    tap = 5'h0f;
      3'h5:    tap = 5'h10;
      3'h6:    tap = 5'h11;
      default: tap = 5'h12;
    endcase
    return tap;
  endfunction : wwc_tap

endpackage : wwc_pkg

//--- hdl/wwc_edge_detect.sv
// rising and falling edge detector for a group of synchronous inputs
// assumes inputs already synchronous to hclk
`timescale 1ns/10ps

module wwc_edge_detect #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] prev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev <= '1;
    end else if (ce) begin
      prev <= d;
    end
  end

  // held high at reset so nothing pulled high looks like a fall
  assign rise = ce ? (d & ~prev) : '0;
  assign fall = ce ? (~d & prev) : '0;

endmodule : wwc_edge_detect

//--- hdl/wwc_wdt_counter.sv
// watchdog up-counter advanced by low-speed clock ticks
// assumes tick is a one-cycle pulse per low-speed clock rising edge
`timescale 1ns/10ps

module wwc_wdt_counter
  import wwc_pkg::*;
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 ce,
  input  wire logic                 tick,
  input  wire logic                 clear,
  input  wire logic                 run,
  input  wire logic [2:0]           sel,
  output logic                      overflow,
  output logic      [WDT_WIDTH-1:0] count
);
  logic [WDT_WIDTH:0]   next_count;
  logic [4:0]           tap;

  assign tap        = wwc_tap(sel);                                    // RULE_12
  assign next_count = {1'b0, count} + {{WDT_WIDTH{1'b0}}, 1'b1};       // RULE_23
  assign overflow   = ce && run && tick && !clear && next_count[tap];  // RULE_23

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= '0;
    end else if (ce) begin
      if (clear || overflow) begin
        count <= '0;                                                   // RULE_19
      end else if (run && tick) begin
        count <= next_count[WDT_WIDTH-1:0];                            // RULE_11
      end
    end
  end

endmodule : wwc_wdt_counter

//--- hdl/wwc_watchdog_wakeup.sv
// watchdog timer with keyed enable, reset-cause flags and low-power wake-up control
// assumes cpu events arrive as one-cycle pulses synchronous to hclk, hresetn is power-on
// reset, and the low-speed rc clock is sampled as an ordinary synchronous input
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps

module wwc_watchdog_wakeup
  import wwc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // configuration option and clocks
  input  wire logic        cfg_watchdog_always_on,
  input  wire logic        low_speed_rc_clock,
  // cpu side
  input  wire logic        halt_exec,
  input  wire logic        clear_watchdog_exec,
  input  wire logic [7:0]  irq_request,
  input  wire logic [7:0]  irq_enable,
  input  wire logic        stack_full,
  input  wire logic        time_base_zero_irq,
  input  wire logic [7:0]  port_a_pins,
  // results
  output wwc_mode_t        low_power_mode,
  output logic             cpu_halted,
  output logic             device_reset_req,
  output logic             pc_sp_clear,
  output logic             wake_resume_next,
  output logic             wake_restart_zero,
  output logic             wake_irq_service,
  output logic             power_down_flag,
  output logic             timeout_flag,
  output logic             watchdog_running
);

  // ==========================================================
  // registers and state
  logic [7:0]  watchdog_control;
  logic [3:0]  reset_cause_flags;
  logic [7:0]  port_a_wake_enable;
  logic [2:0]  power_control;
  logic [7:0]  irq_armed;
  logic        tb0_armed;
  logic        key_pending;
  logic [15:0] key_delay;

  // ==========================================================
  // bus decode
  logic        addr_phase;
  logic        dphase_write;
  logic [7:0]  dphase_addr;
  logic        wr_control;
  logic        wr_flags;
  logic        wr_wake_en;
  logic        wr_power;
  logic [31:0] read_mux;

  assign hreadyout  = ce;
  assign hresp      = 1'b0;
  assign addr_phase = hsel && htrans[1] && hready && ce;
  assign wr_control = dphase_write && (dphase_addr == ADDR_WATCHDOG_CONTROL);
  assign wr_flags   = dphase_write && (dphase_addr == ADDR_RESET_CAUSE_FLAGS);
  assign wr_wake_en = dphase_write && (dphase_addr == ADDR_PORT_A_WAKE);
  assign wr_power   = dphase_write && (dphase_addr == ADDR_POWER_CONTROL);

  // ==========================================================
  // edges of sampled inputs
  logic [7:0] pa_fall;
  logic [8:0] irq_rise;
  logic       low_speed_rc_osc_tick;

  wwc_edge_detect #(.W(8)) u_port_a_edges (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (port_a_pins),
    .rise    (),
    .fall    (pa_fall)
  );

  wwc_edge_detect #(.W(9)) u_irq_edges (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       ({time_base_zero_irq, irq_request}),
    .rise    (irq_rise),
    .fall    ()
  );

  wwc_edge_detect #(.W(1)) u_low_speed_rc_osc_edge (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (low_speed_rc_clock),
    .rise    (low_speed_rc_osc_tick),                                             // RULE_11
    .fall    ()
  );

  // ==========================================================
  // key decode and watchdog enable
  logic [4:0] key;
  logic [2:0] sel;
  logic       key_valid;
  logic       key_fire;

  assign key       = watchdog_control[KEY_LSB +: 5];
  assign sel       = watchdog_control[SEL_LSB +: 3];
  assign key_valid = (key == KEY_RUN) || (key == KEY_STOP);
  // the option forces running for either valid key; register mode obeys the key
  assign watchdog_running = cfg_watchdog_always_on ? key_valid      // RULE_13
                                                   : (key == KEY_RUN); // RULE_14
  assign key_fire  = key_pending && (key_delay == 16'h0000);          // RULE_15

  // ==========================================================
  // mode choice on halt
  wwc_mode_t  halt_target;
  logic [1:0] idle_bits;

  assign idle_bits = {power_control[PWR_FAST_IDLE], power_control[PWR_SLOW_IDLE]};
  always_comb begin
    if (power_control[PWR_DEEP]) begin
      halt_target = MODE_DEEP;                                         // RULE_21
    end else begin
      case (idle_bits)
        2'b00:   halt_target = MODE_SLEEP;
        2'b01:   halt_target = MODE_IDLE0;
        2'b11:   halt_target = MODE_IDLE1;
        2'b10:   halt_target = MODE_IDLE2;
        default: halt_target = MODE_SLEEP;
      endcase
    end
  end

  // ==========================================================
  // watchdog counter
  logic wdt_clear;
  logic wdt_overflow;
  logic halt_take;

  assign halt_take = ce && halt_exec && (low_power_mode == MODE_RUN);
  // halt clears and restarts it so low-power periods are measured afresh
  assign wdt_clear = halt_take || (ce && clear_watchdog_exec) || key_fire; // RULE_19 RULE_22

  wwc_wdt_counter u_wdt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .ce       (ce),
    .tick     (low_speed_rc_osc_tick),
    .clear    (wdt_clear),
    .run      (watchdog_running),                                     // RULE_22
    .sel      (sel),
    .overflow (wdt_overflow),
    .count    ()
  );

  // ==========================================================
  // wake decisions
  logic       lp;
  logic       deep;
  logic       pin_wake;
  logic [7:0] irq_new;
  logic       tb0_new;
  logic       irq_takes;
  logic       wake_any;

  assign lp        = (low_power_mode != MODE_RUN);
  assign deep      = (low_power_mode == MODE_DEEP);
  assign pin_wake  = lp && |(pa_fall & port_a_wake_enable);           // RULE_05
  assign irq_new   = irq_rise[7:0] & irq_armed;                       // RULE_10
  assign tb0_new   = irq_rise[8] && tb0_armed;                        // RULE_10
  assign irq_takes = |(irq_new & irq_enable) && !stack_full;          // RULE_08

  logic next_resume;
  logic next_restart;
  logic next_service;
  logic next_pcsp;
  logic next_reset;

  always_comb begin
    next_resume  = 1'b0;
    next_restart = 1'b0;
    next_service = 1'b0;
    next_pcsp    = 1'b0;
    next_reset   = key_fire;                                           // RULE_15
    if (deep) begin
      if (pin_wake || tb0_new) begin
        next_restart = 1'b1;                                           // RULE_02 RULE_06 RULE_09
      end
    end else if (lp) begin
      if (pin_wake) begin
        next_resume = 1'b1;                                            // RULE_01 RULE_06
      end else if (wdt_overflow) begin
        next_pcsp = 1'b1;                                              // RULE_01 RULE_04
      end else if (|irq_new) begin
        next_service = irq_takes;                                      // RULE_08
        next_resume  = !irq_takes;                                     // RULE_07
      end
    end else if (wdt_overflow) begin
      next_reset = 1'b1;                                               // RULE_18
    end
  end

  // a deep sleep wake restarts from zero and is signalled as such, not as resume
  assign wake_any = next_resume || next_restart || next_service || next_pcsp;

  // ==========================================================
  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_write <= 1'b0;
      dphase_addr  <= 8'h00;
    end else if (ce) begin
      dphase_write <= addr_phase && hwrite;
      dphase_addr  <= haddr;
    end
  end

  always_comb begin
    case (haddr)
      ADDR_WATCHDOG_CONTROL:  read_mux = {24'h0000_00, watchdog_control};
      ADDR_RESET_CAUSE_FLAGS: read_mux = {28'h000_0000, reset_cause_flags};
      ADDR_PORT_A_WAKE:       read_mux = {24'h0000_00, port_a_wake_enable};
      ADDR_POWER_CONTROL:     read_mux = {29'h0000_0000, power_control};
      ADDR_STATUS:            read_mux = {25'h000_0000, low_power_mode, 1'b0,
                                          watchdog_running, timeout_flag,
                                          power_down_flag};
      default:                read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      hrdata <= (addr_phase && !hwrite) ? read_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_control   <= WDC_RESET;                                 // RULE_16
      port_a_wake_enable <= WAKE_EN_RESET;
      power_control      <= PWR_RESET;
    end else if (ce) begin
      if (key_fire) begin
        watchdog_control <= WDC_RESET;
      end else if (wr_control) begin
        watchdog_control <= hwdata[7:0];
      end
      if (wr_wake_en) begin
        port_a_wake_enable <= hwdata[7:0];
      end
      if (wr_power) begin
        power_control <= hwdata[2:0];
      end
    end
  end

  // set beats a same-cycle software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_cause_flags <= FLAGS_RESET;
    end else if (ce) begin
      if (wr_flags) begin
        reset_cause_flags <= hwdata[3:0];
      end
      if (key_fire) begin
        reset_cause_flags[FLAG_WATCHDOG] <= 1'b1;                      // RULE_17
      end
    end
  end

  // ==========================================================
  // key reset delay: once started it runs out even if the key is repaired
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      key_pending <= 1'b0;
      key_delay   <= 16'h0000;
    end else if (ce) begin
      if (key_fire) begin
        key_pending <= 1'b0;
      end else if (!key_pending && !key_valid) begin
        key_pending <= 1'b1;                                           // RULE_15
        key_delay   <= 16'(KEY_RESET_CYCLES - 1);
      end else if (key_pending) begin
        key_delay   <= key_delay - 16'h0001;
      end
    end
  end

  // ==========================================================
  // mode, arming and status flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_power_mode <= MODE_RUN;
      irq_armed      <= 8'h00;
      tb0_armed      <= 1'b0;
    end else if (ce) begin
      if (halt_take) begin
        low_power_mode <= halt_target;                                 // RULE_21
        irq_armed      <= ~irq_request;                                // RULE_10
        tb0_armed      <= ~time_base_zero_irq;
      end else if (wake_any || next_reset) begin
        low_power_mode <= MODE_RUN;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_down_flag <= 1'b0;                                         // RULE_03
      timeout_flag    <= 1'b0;
    end else if (ce) begin
      if (halt_take) begin
        power_down_flag <= 1'b1;                                       // RULE_03
        timeout_flag    <= 1'b0;
      end else if (clear_watchdog_exec) begin
        power_down_flag <= 1'b0;                                       // RULE_03
        timeout_flag    <= 1'b0;
      end
      // overflow keeps the power-down flag; only timeout changes
      if (wdt_overflow && !deep) begin
        timeout_flag <= 1'b1;                                          // RULE_04 RULE_18
      end
    end
  end

  // ==========================================================
  // registered result pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      device_reset_req  <= 1'b0;
      pc_sp_clear       <= 1'b0;
      wake_resume_next  <= 1'b0;
      wake_restart_zero <= 1'b0;
      wake_irq_service  <= 1'b0;
    end else if (ce) begin
      device_reset_req  <= next_reset;
      pc_sp_clear       <= next_pcsp;                                  // RULE_04
      wake_resume_next  <= next_resume;
      wake_restart_zero <= next_restart;
      wake_irq_service  <= next_service;
    end
  end

  assign cpu_halted = lp;

endmodule : wwc_watchdog_wakeup

//--- sim/wwc_watchdog_checker.sv
// port assertions for the watchdog and wake-up block
// assumes one hclk domain, hresetn as power-on reset, bound at the foot of this file
`timescale 1ns/10ps

module wwc_watchdog_checker
  import wwc_pkg::*;
(
  input wire logic      hclk,
  input wire logic      hresetn,
  input wire logic      ce,
  input wire logic      hreadyout,
  input wire logic      hresp,
  input wire logic      halt_exec,
  input wire logic      clear_watchdog_exec,
  input wire wwc_mode_t low_power_mode,
  input wire logic      cpu_halted,
  input wire logic      device_reset_req,
  input wire logic      pc_sp_clear,
  input wire logic      wake_resume_next,
  input wire logic      wake_restart_zero,
  input wire logic      wake_irq_service,
  input wire logic      power_down_flag,
  input wire logic      timeout_flag
);
  // ==========================================================
  // shared timing
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence halt_taken;
    ce && halt_exec && low_power_mode == MODE_RUN;
  endsequence

  sequence woken;
    wake_resume_next || wake_restart_zero || wake_irq_service || pc_sp_clear;
  endsequence

  // ==========================================================
  // properties
  halt_enter_a: assert property (halt_taken |=> cpu_halted && power_down_flag && !timeout_flag)
    else $error("halt did not enter low power with flags set");
  clear_flags_a: assert property (ce && clear_watchdog_exec |=> !power_down_flag && !timeout_flag)
    else $error("clear instruction left a flag set");
  halted_level_a: assert property (cpu_halted == (low_power_mode != MODE_RUN))
    else $error("halted level disagrees with mode");
  bus_okay_a: assert property (hreadyout == ce && !hresp)
    else $error("bus ready or response wrong");
  wake_run_a: assert property (woken |-> low_power_mode == MODE_RUN && $past(cpu_halted))
    else $error("wake pulse without halt or mode not back to run");
  deep_only_a: assert property (low_power_mode == MODE_DEEP |=> !wake_irq_service && !pc_sp_clear && !wake_resume_next)
    else $error("deep sleep left by a forbidden source");
  reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
    else $error("reset request longer than one cycle");
  wdt_wake_a: assert property (pc_sp_clear |-> power_down_flag ##[0:1] timeout_flag)
    else $error("watchdog wake without timeout flag");
endmodule : wwc_watchdog_checker

bind wwc_watchdog_wakeup wwc_watchdog_checker u_wwc_watchdog_checker (
  .hclk, .hresetn, .ce, .hreadyout, .hresp, .halt_exec, .clear_watchdog_exec,
  .low_power_mode, .cpu_halted, .device_reset_req, .pc_sp_clear, .wake_resume_next,
  .wake_restart_zero, .wake_irq_service, .power_down_flag, .timeout_flag
);

//--- sim/wwc_rc_osc_model.sv
// stand-in for the low-speed rc oscillator feeding the watchdog
// assumes the block samples it on hclk; period is a parameter, far faster than real
`timescale 1ns/10ps

module wwc_rc_osc_model #(
  parameter int HALF_NS = 200
) (
  output logic low_speed_rc_clock
);
  // free running like the real source; offset keeps edges away from hclk edges
  initial begin
    low_speed_rc_clock = 1'b0;
    #17;
    forever #(HALF_NS) low_speed_rc_clock = ~low_speed_rc_clock;
  end
endmodule : wwc_rc_osc_model

//--- sim/tb_wwc_watchdog_wakeup.sv
// self-checking bench for the watchdog and wake-up block
// assumes the rc model ticks every 4 hclk cycles; hready is fed back from hreadyout
`timescale 1ns/10ps

module tb_wwc_watchdog_wakeup;
  import wwc_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic        cfg_watchdog_always_on = 1'b0, halt_exec = 1'b0, clear_watchdog_exec = 1'b0;
  logic        stack_full = 1'b0, time_base_zero_irq = 1'b0, low_speed_rc_clock;
  logic [7:0]  haddr = 8'h00, irq_request = 8'h00, irq_enable = 8'h00, port_a_pins = 8'hff;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] hwdata = 32'h0000_0000, hrdata, rd;
  wwc_mode_t   low_power_mode;
  logic        cpu_halted, device_reset_req, pc_sp_clear, wake_resume_next;
  logic        wake_restart_zero, wake_irq_service, power_down_flag, timeout_flag;
  logic        watchdog_running, ce = 1'b1;
  int          num_errors = 0, checked = 0, cycles = 0, n;
  wire  [4:0]  pulses = {device_reset_req, pc_sp_clear, wake_irq_service,
                         wake_restart_zero, wake_resume_next};
  // halt cases: idle0 serviced, idle1 disabled, idle2 stack full, sleep serviced
  localparam logic [2:0] PWR_TAB [4] = '{3'h4, 3'h6, 3'h2, 3'h0};
  localparam wwc_mode_t  MODE_TAB [4] = '{MODE_IDLE0, MODE_IDLE1, MODE_IDLE2, MODE_SLEEP};
  localparam logic [7:0] EN_TAB [4] = '{8'h02, 8'h00, 8'h08, 8'h10};
  localparam logic [3:0] SF_TAB = 4'b0100;
  localparam int         IDX_TAB [4] = '{2, 0, 0, 2};
  always #50 hclk = ~hclk;

  wwc_rc_osc_model u_wwc_rc_osc_model (.low_speed_rc_clock);

  wwc_watchdog_wakeup u_wwc_watchdog_wakeup (
    .hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cfg_watchdog_always_on,
    .low_speed_rc_clock, .halt_exec, .clear_watchdog_exec, .irq_request, .irq_enable,
    .stack_full, .time_base_zero_irq, .port_a_pins, .low_power_mode, .cpu_halted,
    .device_reset_req, .pc_sp_clear, .wake_resume_next, .wake_restart_zero,
    .wake_irq_service, .power_down_flag, .timeout_flag, .watchdog_running
  );

  // ==========================================================
  // reporting
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  // ==========================================================
  // bus and cpu event drivers
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdchk

  task automatic do_halt(input logic [2:0] pwr);
    wr(ADDR_POWER_CONTROL, {29'd0, pwr});
    halt_exec <= 1'b1;
    @(posedge hclk);
    halt_exec <= 1'b0;
    @(posedge hclk);
  endtask : do_halt

  task automatic do_clear;
    clear_watchdog_exec <= 1'b1;
    @(posedge hclk);
    clear_watchdog_exec <= 1'b0;
  endtask : do_clear

  // waits for one wake or reset pulse; n holds the cycles it took
  task automatic wait_for(input int idx, input int lim);
    n = 0;
    while (pulses[idx] !== 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk({31'd0, pulses[idx]}, 32'd1);
  endtask : wait_for

  task automatic quiet(input int cyc);
    repeat (cyc) begin
      @(posedge hclk);
      chk({27'd0, pulses}, 32'd0);
    end
  endtask : quiet

  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdchk(ADDR_WATCHDOG_CONTROL, 32'h0000_0053);
    rdchk(ADDR_STATUS, 32'h0000_0004);
    wr(ADDR_WATCHDOG_CONTROL, 32'h0000_00a8);
    rdchk(ADDR_STATUS, 32'h0000_0000);
    cfg_watchdog_always_on <= 1'b1;
    rdchk(ADDR_STATUS, 32'h0000_0004);
    cfg_watchdog_always_on <= 1'b0;
    wr(ADDR_PORT_A_WAKE, 32'h0000_0001);
    rdchk(ADDR_PORT_A_WAKE, 32'h0000_0001);
    rdchk(8'h14, 32'h0000_0000);
    do_halt(3'h0);
    chk({29'd0, low_power_mode}, {29'd0, MODE_SLEEP});
    chk({31'd0, power_down_flag}, 32'd1);
    port_a_pins <= 8'hfd;
    quiet(8);
    port_a_pins <= 8'hfc;
    ce          <= 1'b0;
    quiet(4);
    ce          <= 1'b1;
    wait_for(0, 10);
    port_a_pins <= 8'hff;
    irq_enable <= 8'hff;
    do_halt(3'h1);
    chk({29'd0, low_power_mode}, {29'd0, MODE_DEEP});
    irq_request <= 8'h81;
    quiet(8);
    time_base_zero_irq <= 1'b1;
    wait_for(1, 10);
    time_base_zero_irq <= 1'b0;
    do_halt(3'h1);
    port_a_pins <= 8'hfe;
    wait_for(1, 10);
    port_a_pins <= 8'hff;
    for (int i = 0; i < 4; i++) begin
      irq_enable <= EN_TAB[i];
      stack_full <= SF_TAB[i];
      do_halt(PWR_TAB[i]);
      chk({29'd0, low_power_mode}, {29'd0, MODE_TAB[i]});
      quiet(6);
      irq_request[i + 1] <= 1'b1;
      wait_for(IDX_TAB[i], 10);
    end
    do_clear();
    rdchk(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_WATCHDOG_CONTROL, 32'h0000_0050);
    do_clear();
    wait_for(4, 1100);
    chk({31'd0, n >= 1015 && n <= 1035}, 32'd1);
    chk({31'd0, timeout_flag}, 32'd1);
    do_halt(3'h0);
    wait_for(3, 1100);
    @(posedge hclk);
    chk({30'd0, timeout_flag, power_down_flag}, 32'd3);
    wr(ADDR_WATCHDOG_CONTROL, 32'h0000_0000);
    wait_for(4, 260);
    chk({31'd0, n >= 195}, 32'd1);
    rdchk(ADDR_RESET_CAUSE_FLAGS, 32'h0000_0001);
    rdchk(ADDR_WATCHDOG_CONTROL, 32'h0000_0053);
    wr(ADDR_RESET_CAUSE_FLAGS, 32'h0000_0000);
    rdchk(ADDR_RESET_CAUSE_FLAGS, 32'h0000_0000);
    close_out();
  end
endmodule : tb_wwc_watchdog_wakeup
